// ==== core/ucs_consts.svh ====
`ifndef UCS_CONSTS_SVH
`define UCS_CONSTS_SVH
// ==========================================
// register offsets
`define UCS_OFF_DATA   3'h0
`define UCS_OFF_IER    3'h1
`define UCS_OFF_ISR    3'h2
`define UCS_OFF_LCR    3'h3
`define UCS_OFF_MCR    3'h4
`define UCS_OFF_LSR    3'h5
`define UCS_OFF_MSR    3'h6
`define UCS_OFF_SPR    3'h7
// ==========================================
// field positions
`define UCS_LCR_DLAB   7
`define UCS_LCR_BRK    6
`define UCS_LCR_STICK  5
`define UCS_LCR_EVEN   4
`define UCS_LCR_PEN    3
`define UCS_LCR_STB    2
`define UCS_MCR_LOOP   4
`define UCS_MCR_RTS    1
`define UCS_MCR_DTR    0
`define UCS_IER_RX     0
`define UCS_IER_TX     1
`define UCS_IER_LS     2
`define UCS_FCR_EN     0
`define UCS_FCR_RXRST  1
`define UCS_FCR_TXRST  2
// ==========================================
// reset values and masks
`define UCS_LCR_RST    8'h03
`define UCS_DIV_RST    16'h0001
`define UCS_FCR_KEEP   8'hc9
`define UCS_IER_KEEP   8'h0f
`define UCS_MCR_KEEP   8'h1f
// ==========================================
// interrupt source codes
`define UCS_ISR_NONE   4'h1
`define UCS_ISR_LINE   4'h6
`define UCS_ISR_RXD    4'h4
`define UCS_ISR_TMO    4'hc
`define UCS_ISR_TX     4'h2
// ==========================================
// timing and sizes
`define UCS_PRE_LAST   4'hf
`define UCS_BIT_LAST   4'hf
`define UCS_START_MID  4'h7
`define UCS_MIN_WORD   3'h4
`define UCS_TMO_BASE   7'h05
`define UCS_TMO_WORDS  7'h04
`define UCS_TMO_EXTRA  7'h0c
`define UCS_TRIG_1     5'h01
`define UCS_TRIG_4     5'h04
`define UCS_TRIG_8     5'h08
`define UCS_TRIG_14    5'h0e
`define UCS_RX_W       11
`endif

// ==== core/ucs_pkg.sv ====
package ucs_pkg;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ucs_tx_e;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ucs_rx_e;
endpackage

// ==== core/ucs_baud_gen.sv ====
`timescale 1ns/1ps
`include "ucs_consts.svh"
module ucs_baud_gen (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// divisor and sampling enable
	input  wire logic [15:0] divisor,
	output logic             sampleTick
);
	logic [3:0]  pre_reg;
	logic [15:0] divCnt_reg;
	logic [15:0] divPrev_reg;
	logic        preTick;

	// ==========================================
	// fixed divide by sixteen
	assign preTick = (pre_reg == `UCS_PRE_LAST);
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pre_reg <= 4'h0;
		end else begin
			pre_reg <= pre_reg + 4'h1;
		end
	end

	// ==========================================
	// programmable divider, reloaded on expiry or when the divisor changes
	// a zero divisor stalls the ticks rather than wrapping to 65536
	// restart on a new divisor so a large old count cannot delay the new rate
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			divCnt_reg <= 16'h0000;
			divPrev_reg <= 16'h0000;
			sampleTick <= 1'b0;
		end else begin
			sampleTick <= 1'b0;
			divPrev_reg <= divisor;
			if (divisor != divPrev_reg) begin
				divCnt_reg <= divisor;
			end else if (preTick) begin
				if (divCnt_reg <= 16'h0001) begin
					divCnt_reg <= divisor;
					sampleTick <= (divisor != 16'h0000);
				end else begin
					divCnt_reg <= divCnt_reg - 16'h0001;
				end
			end
		end
	end

	a_prescale_period: assert property (@(posedge sys_clk) disable iff (!rst_n)
		preTick |-> ##16 preTick)
		else $error("prescaler period is not sixteen clocks");
	a_tick_on_prescale: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sampleTick |-> $past(preTick) && $past(divCnt_reg) <= 16'h0001)
		else $error("sampling tick without divider expiry");
endmodule

// ==== core/ucs_fifo.sv ====
`timescale 1ns/1ps
module ucs_fifo #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic         flush,
	// write side
	input  wire logic         push,
	input  wire logic [W-1:0] pushData,
	// read side
	input  wire logic         pop,
	output logic      [W-1:0] headData,
	output logic      [4:0]   count,
	output logic              empty,
	output logic              full
);
	logic [W-1:0] mem_reg [16];
	logic [3:0]   wrPtr_reg;
	logic [3:0]   rdPtr_reg;
	logic         doPush;
	logic         doPop;

	// ==========================================
	// flags; pushes when full and pops when empty are dropped
	assign empty = (count == 5'h00);
	assign full = count[4];
	assign doPush = push && !full;
	assign doPop = pop && !empty;
	assign headData = mem_reg[rdPtr_reg];

	always_ff @(posedge sys_clk) begin
		if (doPush) begin
			mem_reg[wrPtr_reg] <= pushData;
		end
	end

	// ==========================================
	// pointers and fill level
	always_ff @(posedge sys_clk) begin
		if (!rst_n || flush) begin
			wrPtr_reg <= 4'h0;
			rdPtr_reg <= 4'h0;
			count <= 5'h00;
		end else begin
			if (doPush) begin
				wrPtr_reg <= wrPtr_reg + 4'h1;
			end
			if (doPop) begin
				rdPtr_reg <= rdPtr_reg + 4'h1;
			end
			count <= count + {4'h0, doPush} - {4'h0, doPop};
		end
	end

	a_fill_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
		count <= 5'h10)
		else $error("fifo holds more than sixteen entries");
	a_push_advance: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(doPush && !doPop && !flush) |=> count == $past(count) + 5'h01)
		else $error("push did not advance the fill level");
endmodule

// ==== core/ucs_serial_core.sv ====
`timescale 1ns/1ps
`include "ucs_consts.svh"
// How it works
// - reference clock is first divided by sixteen.
// - a 16-bit divisor, one to 65535, then divides to the sampling tick.
// - each transmitted bit lasts sixteen sampling ticks.
// - frame is start, data bits, optional parity, one or two stops.
// - data bits leave least significant first.
// - with fifos on, each holding write pushes into a 16-byte transmit fifo.
// - without fifos, holding-empty sets when the byte moves to the shifter.
// - transmit-empty interrupt raised when enabled and holding becomes empty.
// - transmitter-empty flag needs idle shifter and empty fifo.
// - with fifos on, holding-empty follows fifo empty and raises interrupt.
// - start edge validated by a sample eight ticks later, else dropped.
// - data, parity and stop bits sampled at centre, sixteen ticks apart.
// - head character error tags show in line status bits 2 to 4.
// - receive fifo holds sixteen entries of eight data plus three tags.
// - reading receive holding pops the fifo and updates the shown tags.
// - receive-data interrupt per character or at the trigger level.
// - time-out after four word lengths plus twelve bit times of silence.
// - loopback routes shifter output into the receiver.
// - in loopback tx pin is one, modem outputs off, modem inputs ignored.
// - divisor bytes reachable at offsets 0 and 1 only with divisor-access set.
module ucs_serial_core (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// host register port
	input  wire logic       csN,
	input  wire logic       iorN,
	input  wire logic       iowN,
	input  wire logic [2:0] addr,
	input  wire logic [7:0] dataIn,
	output logic      [7:0] dataOut,
	output logic            dataOeN,
	output logic            intOut,
	// serial line
	input  wire logic       rxd,
	output logic            txd,
	// modem pins
	input  wire logic       ctsN,
	input  wire logic       dsrN,
	input  wire logic       cdN,
	input  wire logic       riN,
	output logic            rtsN,
	output logic            dtrN
);
	logic [7:0]  lcr_reg, ier_reg, mcr_reg, fcr_reg, spr_reg;
	logic [15:0] div_reg;
	logic        rdPrev_reg, wrPrev_reg, threPrev_reg, txInt_reg, overrun_reg;
	logic        rdStb, rdGo, wrGo, dlab, fifoOn, loopback;
	logic        thrWrite, rhrRead, isrRead, lsrRead, fcrWrite;
	logic        sampleTick;
	logic [2:0]  wordLast;
	logic [7:0]  wordMask;
	logic [7:0]  readMux;

	// ==========================================
	// host access decode, one action per strobe
	assign rdStb = !csN && !iorN;
	assign rdGo = rdStb && !rdPrev_reg;
	assign wrGo = !csN && !iowN && !wrPrev_reg;
	assign dlab = lcr_reg[`UCS_LCR_DLAB];
	assign fifoOn = fcr_reg[`UCS_FCR_EN];
	assign loopback = mcr_reg[`UCS_MCR_LOOP];
	assign thrWrite = wrGo && addr == `UCS_OFF_DATA && !dlab;
	assign rhrRead = rdGo && addr == `UCS_OFF_DATA && !dlab;
	assign isrRead = rdGo && addr == `UCS_OFF_ISR;
	assign lsrRead = rdGo && addr == `UCS_OFF_LSR;
	assign fcrWrite = wrGo && addr == `UCS_OFF_ISR;
	assign wordLast = `UCS_MIN_WORD + {1'b0, lcr_reg[1:0]};
	assign wordMask = 8'hff >> (2'h3 - lcr_reg[1:0]);
	assign dataOeN = !rdStb;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rdPrev_reg <= 1'b0;
			wrPrev_reg <= 1'b0;
		end else begin
			rdPrev_reg <= rdStb;
			wrPrev_reg <= !csN && !iowN;
		end
	end

	// ==========================================
	// configuration registers
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			lcr_reg <= `UCS_LCR_RST;
			ier_reg <= 8'h00;
			mcr_reg <= 8'h00;
			fcr_reg <= 8'h00;
			spr_reg <= 8'h00;
			div_reg <= `UCS_DIV_RST;
		end else if (wrGo) begin
			case (addr)
				`UCS_OFF_DATA: if (dlab) div_reg[7:0] <= dataIn;
				`UCS_OFF_IER: begin
					if (dlab) div_reg[15:8] <= dataIn;
					else ier_reg <= dataIn & `UCS_IER_KEEP;
				end
				`UCS_OFF_ISR: fcr_reg <= dataIn & `UCS_FCR_KEEP;
				`UCS_OFF_LCR: lcr_reg <= dataIn;
				`UCS_OFF_MCR: mcr_reg <= dataIn & `UCS_MCR_KEEP;
				`UCS_OFF_SPR: spr_reg <= dataIn;
				default: ;
			endcase
		end
	end

	ucs_baud_gen u_baud (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.divisor    (div_reg),
		.sampleTick (sampleTick)
	);

	// even or odd parity bit of the active data bits, per the even-select bit; stick parity forces it
	function automatic logic parityOf(input logic [7:0] d, input logic [7:0] line_control,
		input logic [7:0] mask);
		logic p;
		p = ^(d & mask);
		if (line_control[`UCS_LCR_STICK]) parityOf = !line_control[`UCS_LCR_EVEN];
		else parityOf = line_control[`UCS_LCR_EVEN] ? p : !p;
	endfunction

	// ==========================================
	// transmit fifo; one byte deep when fifos are off
	logic [7:0] txHead;
	logic [4:0] txCount;
	logic       txEmpty, txFull, txPop, txFlush;
	assign txFlush = fcrWrite && (dataIn[`UCS_FCR_TXRST] || dataIn[`UCS_FCR_EN] != fifoOn);

	ucs_fifo #(.W(8)) u_txfifo (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.flush    (txFlush),
		.push     (thrWrite && (fifoOn || txEmpty)),
		.pushData (dataIn),
		.pop      (txPop),
		.headData (txHead),
		.count    (txCount),
		.empty    (txEmpty),
		.full     (txFull)
	);

	// ==========================================
	// transmit shifter
	ucs_pkg::ucs_tx_e txState_reg;
	logic [3:0] txCnt_reg;
	logic [2:0] txBit_reg;
	logic [7:0] txShift_reg;
	logic       txPar_reg, txLine, txBitEnd;
	assign txPop = (txState_reg == ucs_pkg::TX_IDLE) && !txEmpty;
	assign txBitEnd = sampleTick && txCnt_reg == `UCS_BIT_LAST;

	always_comb begin
		case (txState_reg)
			ucs_pkg::TX_START: txLine = 1'b0;
			ucs_pkg::TX_DATA: txLine = txShift_reg[0];
			ucs_pkg::TX_PAR: txLine = txPar_reg;
			default: txLine = 1'b1;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n || txState_reg == ucs_pkg::TX_IDLE) begin
			txCnt_reg <= 4'h0;
		end else if (sampleTick) begin
			txCnt_reg <= txCnt_reg + 4'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			txState_reg <= ucs_pkg::TX_IDLE;
			txBit_reg <= 3'h0;
			txShift_reg <= 8'h00;
			txPar_reg <= 1'b0;
		end else begin
			case (txState_reg)
				ucs_pkg::TX_IDLE: if (txPop) begin
					txState_reg <= ucs_pkg::TX_START;
					txShift_reg <= txHead;
					txPar_reg <= parityOf(txHead, lcr_reg, wordMask);
				end
				ucs_pkg::TX_START: if (txBitEnd) begin
					txState_reg <= ucs_pkg::TX_DATA;
					txBit_reg <= 3'h0;
				end
				ucs_pkg::TX_DATA: if (txBitEnd) begin
					txShift_reg <= {1'b0, txShift_reg[7:1]};
					txBit_reg <= txBit_reg + 3'h1;
					if (txBit_reg == wordLast) begin
						txBit_reg <= 3'h0;
						txState_reg <= lcr_reg[`UCS_LCR_PEN] ? ucs_pkg::TX_PAR
							: ucs_pkg::TX_STOP;
					end
				end
				ucs_pkg::TX_PAR: if (txBitEnd) begin
					txState_reg <= ucs_pkg::TX_STOP;
					txBit_reg <= 3'h0;
				end
				ucs_pkg::TX_STOP: if (txBitEnd) begin
					// second stop bit reuses the bit counter
					if (lcr_reg[`UCS_LCR_STB] && txBit_reg == 3'h0) txBit_reg <= 3'h1;
					else txState_reg <= ucs_pkg::TX_IDLE;
				end
				default: txState_reg <= ucs_pkg::TX_IDLE;
			endcase
		end
	end

	// ==========================================
	// pin drivers; loopback parks the line and modem outputs
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			txd <= 1'b1;
			rtsN <= 1'b1;
			dtrN <= 1'b1;
		end else begin
			txd <= loopback || (txLine && !lcr_reg[`UCS_LCR_BRK]);
			rtsN <= loopback || !mcr_reg[`UCS_MCR_RTS];
			dtrN <= loopback || !mcr_reg[`UCS_MCR_DTR];
		end
	end

	// ==========================================
	// receive shifter
	ucs_pkg::ucs_rx_e rxState_reg;
	logic [3:0] rxCnt_reg;
	logic [2:0] rxBit_reg;
	logic [7:0] rxShift_reg, rxData;
	logic       rxIn, rxPrev_reg, rxZero_reg, rxPar_reg, rxMid, rxPush;
	logic [`UCS_RX_W-1:0] rxHead;
	logic [4:0] rxCount;
	logic       rxEmpty, rxFull, rxFullEff, rxFlush;
	assign rxIn = loopback ? txLine : rxd;
	assign rxMid = sampleTick && rxCnt_reg == ((rxState_reg == ucs_pkg::RX_START)
		? `UCS_START_MID : `UCS_BIT_LAST);
	assign rxData = rxShift_reg >> (2'h3 - lcr_reg[1:0]);
	assign rxPush = rxState_reg == ucs_pkg::RX_STOP && rxMid;
	assign rxFullEff = fifoOn ? rxFull : !rxEmpty;
	assign rxFlush = fcrWrite && (dataIn[`UCS_FCR_RXRST] || dataIn[`UCS_FCR_EN] != fifoOn);

	always_ff @(posedge sys_clk) begin
		if (!rst_n || rxState_reg == ucs_pkg::RX_IDLE) begin
			rxCnt_reg <= 4'h0;
		end else if (sampleTick) begin
			rxCnt_reg <= rxMid ? 4'h0 : rxCnt_reg + 4'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rxState_reg <= ucs_pkg::RX_IDLE;
			rxPrev_reg <= 1'b1;
			rxBit_reg <= 3'h0;
			rxShift_reg <= 8'h00;
			rxZero_reg <= 1'b0;
			rxPar_reg <= 1'b0;
		end else begin
			rxPrev_reg <= rxIn;
			case (rxState_reg)
				ucs_pkg::RX_IDLE: if (rxPrev_reg && !rxIn) begin
					rxState_reg <= ucs_pkg::RX_START;
					rxZero_reg <= 1'b1;
				end
				ucs_pkg::RX_START: if (rxMid) begin
					rxBit_reg <= 3'h0;
					// a high sample here means a glitch, not a start
					rxState_reg <= rxIn ? ucs_pkg::RX_IDLE : ucs_pkg::RX_DATA;
				end
				ucs_pkg::RX_DATA: if (rxMid) begin
					rxShift_reg <= {rxIn, rxShift_reg[7:1]};
					rxZero_reg <= rxZero_reg && !rxIn;
					rxBit_reg <= rxBit_reg + 3'h1;
					if (rxBit_reg == wordLast) begin
						rxState_reg <= lcr_reg[`UCS_LCR_PEN] ? ucs_pkg::RX_PAR
							: ucs_pkg::RX_STOP;
					end
				end
				ucs_pkg::RX_PAR: if (rxMid) begin
					rxPar_reg <= rxIn;
					rxZero_reg <= rxZero_reg && !rxIn;
					rxState_reg <= ucs_pkg::RX_STOP;
				end
				ucs_pkg::RX_STOP: if (rxMid) rxState_reg <= ucs_pkg::RX_IDLE;
				default: rxState_reg <= ucs_pkg::RX_IDLE;
			endcase
		end
	end

	// ==========================================
	// receive fifo with break, framing and parity tags
	ucs_fifo #(.W(`UCS_RX_W)) u_rxfifo (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.flush    (rxFlush),
		.push     (rxPush && !rxFullEff),
		.pushData ({rxZero_reg && !rxIn, !rxIn, lcr_reg[`UCS_LCR_PEN]
			&& (rxPar_reg != parityOf(rxData, lcr_reg, wordMask)), rxData}),
		.pop      (rhrRead),
		.headData (rxHead),
		.count    (rxCount),
		.empty    (rxEmpty),
		.full     (rxFull)
	);

	// overrun sticks until line status is read; a new overrun wins
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			overrun_reg <= 1'b0;
		end else if (rxPush && rxFullEff) begin
			overrun_reg <= 1'b1;
		end else if (lsrRead) begin
			overrun_reg <= 1'b0;
		end
	end

	// ==========================================
	// receive time-out, counted in bit times
	logic [3:0] tmoSub_reg;
	logic [6:0] tmoBits_reg, tmoLimit;
	logic       tmoHit;
	assign tmoLimit = (`UCS_TMO_BASE + {5'h00, lcr_reg[1:0]}) * `UCS_TMO_WORDS
		+ `UCS_TMO_EXTRA;
	assign tmoHit = fifoOn && !rxEmpty && tmoBits_reg >= tmoLimit;

	always_ff @(posedge sys_clk) begin
		if (!rst_n || rxEmpty || rxPush || rhrRead) begin
			tmoSub_reg <= 4'h0;
			tmoBits_reg <= 7'h00;
		end else if (sampleTick && !tmoHit) begin
			tmoSub_reg <= tmoSub_reg + 4'h1;
			if (tmoSub_reg == `UCS_BIT_LAST) tmoBits_reg <= tmoBits_reg + 7'h01;
		end
	end

	// ==========================================
	// transmit-empty interrupt; a new empty event beats a clear
	logic [3:0] isrCode;
	logic       thre, temt, lineInt, rxLevel;
	logic [4:0] trigLevel;
	assign thre = txEmpty;
	assign temt = txEmpty && txState_reg == ucs_pkg::TX_IDLE;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			threPrev_reg <= 1'b1;
			txInt_reg <= 1'b0;
		end else begin
			threPrev_reg <= thre;
			if (thre && (!threPrev_reg || (wrGo && addr == `UCS_OFF_IER && !dlab
				&& dataIn[`UCS_IER_TX] && !ier_reg[`UCS_IER_TX]))) begin
				txInt_reg <= 1'b1;
			end else if (thrWrite || (isrRead && isrCode == `UCS_ISR_TX)) begin
				txInt_reg <= 1'b0;
			end
		end
	end

	// ==========================================
	// interrupt priority and status words
	always_comb begin
		case (fcr_reg[7:6])
			2'h0: trigLevel = `UCS_TRIG_1;
			2'h1: trigLevel = `UCS_TRIG_4;
			2'h2: trigLevel = `UCS_TRIG_8;
			default: trigLevel = `UCS_TRIG_14;
		endcase
	end

	assign lineInt = overrun_reg || (!rxEmpty && rxHead[10:8] != 3'h0);
	assign rxLevel = fifoOn ? rxCount >= trigLevel : !rxEmpty;

	always_comb begin
		if (ier_reg[`UCS_IER_LS] && lineInt) isrCode = `UCS_ISR_LINE;
		else if (ier_reg[`UCS_IER_RX] && rxLevel) isrCode = `UCS_ISR_RXD;
		else if (ier_reg[`UCS_IER_RX] && tmoHit) isrCode = `UCS_ISR_TMO;
		else if (ier_reg[`UCS_IER_TX] && txInt_reg) isrCode = `UCS_ISR_TX;
		else isrCode = `UCS_ISR_NONE;
	end

	always_comb begin
		case (addr)
			`UCS_OFF_DATA: readMux = dlab ? div_reg[7:0] : rxHead[7:0];
			`UCS_OFF_IER: readMux = dlab ? div_reg[15:8] : ier_reg;
			`UCS_OFF_ISR: readMux = {fifoOn, fifoOn, 2'h0, isrCode};
			`UCS_OFF_LCR: readMux = lcr_reg;
			`UCS_OFF_MCR: readMux = mcr_reg;
			`UCS_OFF_LSR: readMux = {fifoOn && lineInt, temt, thre,
				rxEmpty ? 3'h0 : rxHead[10:8], overrun_reg, !rxEmpty};
			`UCS_OFF_MSR: readMux = loopback ? 8'h00
				: {!cdN, !riN, !dsrN, !ctsN, 4'h0};
			default: readMux = spr_reg;
		endcase
	end

	// read data captured once at the start of the strobe
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			dataOut <= 8'h00;
			intOut <= 1'b0;
		end else begin
			if (rdGo) dataOut <= readMux;
			intOut <= isrCode != `UCS_ISR_NONE;
		end
	end

	a_loop_txd_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$past(loopback) |-> txd && rtsN && dtrN)
		else $error("loopback left a line or modem output active");
	a_temt_implies_thre: assert property (@(posedge sys_clk) disable iff (!rst_n)
		temt |-> thre && txState_reg == ucs_pkg::TX_IDLE && txCount == 5'h00)
		else $error("transmitter empty while data remains");
	a_tx_bit_width: assert property (@(posedge sys_clk) disable iff (!rst_n)
		($past(txState_reg) != ucs_pkg::TX_IDLE && txState_reg != ucs_pkg::TX_IDLE
		&& txLine != $past(txLine)) |-> $past(txBitEnd))
		else $error("transmit bit changed before sixteen ticks");
	a_start_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(txState_reg == ucs_pkg::TX_START) |-> !txLine ##1 !txLine)
		else $error("start bit not driven low");
	a_start_reject: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(rxState_reg == ucs_pkg::RX_START && rxMid && rxIn)
		|=> rxState_reg == ucs_pkg::RX_IDLE && !rxPush)
		else $error("false start bit was not discarded");
	a_rx_pop_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(rhrRead && !rxEmpty && !rxPush && !rxFlush) |=> rxCount == $past(rxCount) - 5'h01)
		else $error("holding read did not advance the receive fifo");
	a_overrun_drop: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(rxPush && rxFullEff && !rhrRead && !rxFlush)
		|=> overrun_reg && rxCount == $past(rxCount))
		else $error("overrun not flagged or character stored");
	a_dlab_no_push: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(wrGo && addr == `UCS_OFF_DATA && dlab && !txPop && !txFlush)
		|=> txCount == $past(txCount) && div_reg[7:0] == $past(dataIn))
		else $error("divisor write reached the transmit fifo");
endmodule

// ==== verif/ucs_serial_peer.sv ====
`timescale 1ns/1ps
// ==========================================
// far-end serial device, 8N1, fixed bit time
module ucs_serial_peer #(
	parameter int BIT = 256
) (
	// clock and lines
	input  wire logic sys_clk,
	input  wire logic txd,
	output logic      rxd
);
	// idle at mark, loopback included, so no false break appears
	initial rxd = 1'b1;
	// frame out: start, data lsb first, stop
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (BIT) @(posedge sys_clk);
		end
	endtask
	// low pulse shorter than half a bit
	task automatic glitch(input int n);
		rxd <= 1'b0;
		repeat (n) @(posedge sys_clk);
		rxd <= 1'b1;
	endtask
	// sampled on falling clock edges to stay clear of txd updates
	task automatic recv_byte(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		b = 8'h00;
		while (txd !== 1'b0 && n < 4000) begin
			@(negedge sys_clk);
			n++;
		end
		repeat (BIT / 2) @(negedge sys_clk);
		ok = (n < 4000) && (txd === 1'b0);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(negedge sys_clk);
			b[i] = txd;
		end
		repeat (BIT) @(negedge sys_clk);
		ok = ok && (txd === 1'b1);
	endtask
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
// ==========================================
// top: design, far end, host-side tasks
module testbench;
	logic       sysClk, rstN, csN, iorN, iowN, txd, dataOeN, intOut, rtsN, dtrN, rxd;
	logic [2:0] addr;
	logic [7:0] dataIn, dataOut, v, rxb;
	logic [3:0] mdmN;
	logic       ok;
	int         n_mismatch, comparisons;
	ucs_serial_core i_dut (.sys_clk(sysClk), .rst_n(rstN), .csN(csN), .iorN(iorN),
		.iowN(iowN), .addr(addr), .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN),
		.intOut(intOut), .rxd(rxd), .txd(txd), .ctsN(mdmN[0]), .dsrN(mdmN[1]),
		.cdN(mdmN[2]), .riN(mdmN[3]), .rtsN(rtsN), .dtrN(dtrN));
	ucs_serial_peer #(.BIT(256)) i_peer (.sys_clk(sysClk), .txd(txd), .rxd(rxd));
	// 50 MHz clock
	initial sysClk = 1'b0;
	always #10 sysClk = ~sysClk;
	// ==========================================
	// helpers
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sysClk);
	endtask
	// strobe held two edges, then one idle edge before the next access
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		csN <= 1'b0; iowN <= 1'b0; addr <= a; dataIn <= d;
		tick(2);
		csN <= 1'b1; iowN <= 1'b1;
		tick(1);
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		csN <= 1'b0; iorN <= 1'b0; addr <= a;
		tick(2);
		d = dataOut;
		check("data enable", {7'h00, dataOeN}, 8'h00);
		csN <= 1'b1; iorN <= 1'b1;
		tick(1);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ==========================================
	// scenarios
	task automatic test_regs();
		rd(3'h3, v); check("line_control reset", v, 8'h03);
		rd(3'h5, v); check("line_status reset", v, 8'h60);
		wr(3'h3, 8'h80); wr(3'h0, 8'h00); wr(3'h1, 8'h09);
		rd(3'h0, v); check("divisor low", v, 8'h00);
		rd(3'h1, v); check("divisor_high", v, 8'h09);
		wr(3'h1, 8'h00); wr(3'h0, 8'h01); wr(3'h3, 8'h03);
		rd(3'h1, v); check("interrupt_enable", v, 8'h00);
		$display("test regs done");
	endtask
	task automatic test_tx();
		wr(3'h1, 8'h02);
		check("tx empty irq", {7'h00, intOut}, 8'h01);
		rd(3'h2, v); check("interrupt_status", v, 8'h02);
		wr(3'h1, 8'h00);
		fork
			begin wr(3'h0, 8'ha5); tick(50); rd(3'h5, v); end
			i_peer.recv_byte(rxb, ok);
		join
		check("line_status busy", v, 8'h20);
		check("tx frame", {7'h00, ok}, 8'h01);
		check("tx data", rxb, 8'ha5);
		// the far end returns mid stop bit; let the stop bit finish
		tick(200);
		rd(3'h5, v); check("line_status idle", v, 8'h60);
		$display("test tx done");
	endtask
	task automatic test_rx();
		i_peer.send_byte(8'h3c);
		rd(3'h5, v); check("line_status ready", v, 8'h61);
		rd(3'h0, v); check("receive_holding", v, 8'h3c);
		rd(3'h5, v); check("line_status drained", v, 8'h60);
		i_peer.send_byte(8'h11);
		i_peer.send_byte(8'h22);
		tick(300);
		rd(3'h5, v); check("line_status overrun", v, 8'h63);
		rd(3'h0, v); check("receive_holding kept", v, 8'h11);
		rd(3'h5, v); check("line_status cleared", v, 8'h60);
		i_peer.glitch(64);
		tick(3000);
		rd(3'h5, v); check("false start", v, 8'h60);
		$display("test rx done");
	endtask
	task automatic test_loop();
		mdmN <= 4'ha;
		rd(3'h6, v); check("modem_status", v, 8'h90);
		wr(3'h4, 8'h13);
		wr(3'h0, 8'h5a);
		tick(300);
		check("loop pins", {5'h00, txd, rtsN, dtrN}, 8'h07);
		rd(3'h6, v); check("modem_status loop", v, 8'h00);
		tick(2600);
		rd(3'h5, v); check("loop status", v, 8'h61);
		rd(3'h0, v); check("loop data", v, 8'h5a);
		wr(3'h4, 8'h00);
		$display("test loop done");
	endtask
	// fifo mode: trigger one with parity error, then trigger four with time-out
	task automatic test_fifo();
		wr(3'h2, 8'h01); wr(3'h1, 8'h01); wr(3'h3, 8'h1b);
		i_peer.send_byte(8'h3c);
		tick(300);
		rd(3'h2, v); check("interrupt_status rx", v, 8'hc4);
		rd(3'h5, v); check("line_status parity", v, 8'he5);
		rd(3'h0, v); check("receive_holding fifo", v, 8'h3c);
		rd(3'h5, v); check("line_status next", v, 8'h60);
		wr(3'h3, 8'h03); wr(3'h2, 8'h41);
		i_peer.send_byte(8'h81);
		tick(300);
		rd(3'h2, v); check("interrupt_status below", v, 8'hc1);
		tick(11300);
		rd(3'h2, v); check("interrupt_status timeout", v, 8'hcc);
		check("timeout irq", {7'h00, intOut}, 8'h01);
		rd(3'h0, v); check("receive_holding timeout", v, 8'h81);
		$display("test fifo done");
	endtask
	// ==========================================
	// main sequence
	initial begin
		rstN = 1'b0; csN = 1'b1; iorN = 1'b1; iowN = 1'b1; addr = 3'h0; dataIn = 8'h00;
		n_mismatch = 0; comparisons = 0;
		mdmN = 4'hf;
		tick(6);
		rstN <= 1'b1;
		tick(2);
		test_regs();
		test_tx();
		test_rx();
		test_loop();
		test_fifo();
		tally_and_finish();
	end
endmodule
